//--- rtl/fss_core.sv
// Purpose: Scan, seek, recalibrate and sense-interrupt execution of a disk controller
// Assumes: Disk stream and drive lines synchronous to clk; ce freezes all state
// Notes: Seeks run per drive in parallel; scan owns the busy indication
`timescale 1ns/10ps
`include "fss_map.svh"

module fss_core #(
	parameter int DRIVES = 4,
	parameter int STEP_UNIT_CYCLES = `FSS_MS_NS / `FSS_CLK_NS
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire fss_pkg::fss_disk_t disk_in,
	input wire logic terminal_count,
	output logic scan_data_req,
	input wire logic [DRIVES-1:0] drive_ready,
	input wire logic [DRIVES-1:0] drive_track0,
	output logic [DRIVES-1:0] drive_step,
	output logic [DRIVES-1:0] drive_dir,
	output logic ctrl_busy,
	output logic ctrl_int
);

	// Host byte deadlines in cycles, rounded down
	localparam logic [9:0] FM_LIMIT = 10'(`FSS_FM_LIMIT_NS / `FSS_CLK_NS);
	localparam logic [9:0] MFM_LIMIT = 10'(`FSS_MFM_LIMIT_NS / `FSS_CLK_NS);

	// Step interval in cycles from the interval field
	function automatic logic [23:0] fss_step_cycles(input logic [3:0] step_interval_field);
		logic [4:0] ms;
		ms = `FSS_SRT_SPAN - {1'b0, step_interval_field};
		fss_step_cycles = 24'(ms * STEP_UNIT_CYCLES);
	endfunction

	// Unsigned byte comparison for the three scan kinds
	function automatic logic fss_cond(input logic [2:0] op, input logic [7:0] d, input logic [7:0] h);
		case (op)
			`FSS_OP_SCAN_LE: fss_cond = (d <= h);
			`FSS_OP_SCAN_GE: fss_cond = (d >= h);
			default: fss_cond = (d == h);
		endcase
	endfunction

	logic [31:0] spec;
	logic [31:0] scanp;
	logic [7:0] target_reg;
	logic [2:0] scan_op;
	logic [1:0] scan_drv;
	logic scan_head;
	fss_pkg::fss_scan_state_t scan_state;
	logic [7:0] cur_sector;
	logic [7:0] host_byte;
	logic host_valid;
	logic [9:0] req_timer;
	logic sec_all_cond;
	logic sec_all_eq;
	logic tc_seen;
	logic idx_seen;
	logic last_forced;
	logic cm_seen;
	logic [31:0] scan_res;
	logic scan_int;
	logic [7:0] sense_res_st0;
	logic [7:0] sense_res_pcn;
	fss_pkg::fss_drv_state_t drv_state [DRIVES];
	logic [7:0] present_cylinder [DRIVES];
	logic [7:0] target_cylinder [DRIVES];
	logic [23:0] step_timer [DRIVES];
	logic [6:0] step_count [DRIVES];
	logic [DRIVES-1:0] drv_head;
	logic [DRIVES-1:0] pend;
	logic [DRIVES-1:0] pend_seek;
	logic [7:0] pend_st0 [DRIVES];
	logic [DRIVES-1:0] rdy_q;

	// Command decode
	logic cmd_wr;
	logic [2:0] cmd_op;
	logic [1:0] cmd_drv;
	logic need_sense;
	logic scan_busy;
	logic op_is_scan;
	logic cmd_invalid;
	logic start_scan;
	logic sense_cmd;
	logic byte_take;
	logic req_late;
	logic [9:0] req_limit;
	logic [23:0] step_limit;
	logic sel_found;
	logic [1:0] sel_idx;

	assign cmd_wr = ce && reg_wr && (reg_addr == `FSS_REG_CMD);
	assign cmd_op = reg_wdata[`FSS_CMD_OP];
	assign cmd_drv = reg_wdata[`FSS_CMD_DRV];
	assign need_sense = |pend_seek;
	assign scan_busy = (scan_state != fss_pkg::FSS_SC_IDLE);
	assign op_is_scan = (cmd_op == `FSS_OP_SCAN_EQ) || (cmd_op == `FSS_OP_SCAN_LE) || (cmd_op == `FSS_OP_SCAN_GE);
	// Pending seek interrupt demands sense first; unknown ops and a scan on a scan are invalid
	assign cmd_invalid = cmd_wr && ((need_sense && cmd_op != `FSS_OP_SENSE)
		|| (op_is_scan && scan_busy) || !(op_is_scan || cmd_op == `FSS_OP_SEEK
		|| cmd_op == `FSS_OP_RECAL || cmd_op == `FSS_OP_SENSE));
	assign start_scan = cmd_wr && !cmd_invalid && op_is_scan;
	assign sense_cmd = cmd_wr && !cmd_invalid && (cmd_op == `FSS_OP_SENSE);
	assign ctrl_busy = scan_busy;
	assign ctrl_int = scan_int || (|pend);
	assign step_limit = fss_step_cycles(spec[`FSS_SPEC_SRT]);

	// Host byte handshake and deadline
	assign scan_data_req = (scan_state == fss_pkg::FSS_SC_DATA) && !host_valid;
	assign byte_take = ce && (scan_state == fss_pkg::FSS_SC_DATA) && disk_in.byte_valid && host_valid;
	assign req_limit = spec[`FSS_SPEC_DD] ? MFM_LIMIT : FM_LIMIT;
	assign req_late = (scan_state == fss_pkg::FSS_SC_DATA) && !host_valid
		&& (disk_in.byte_valid || req_timer >= req_limit);

	// Lowest drive with a pending event is reported first
	always_comb begin
		sel_found = 1'b0;
		sel_idx = 2'h0;
		for (int i = DRIVES - 1; i >= 0; i--) begin
			if (pend[i]) begin
				sel_found = 1'b1;
				sel_idx = 2'(i);
			end
		end
	end

	// Configuration registers written by software
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			spec <= `FSS_SPEC_RST;
			scanp <= `FSS_SCANP_RST;
			target_reg <= `FSS_BYTE_ZERO;
		end else if (ce && reg_wr) begin
			case (reg_addr)
				`FSS_REG_SPEC: spec <= reg_wdata;
				`FSS_REG_SCANP: scanp <= reg_wdata;
				`FSS_REG_TARGET: target_reg <= reg_wdata[`FSS_TARGET_CYL];
				default: ;
			endcase
		end
	end

	// Host comparison byte; a fresh write wins over consumption
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			host_byte <= `FSS_BYTE_ZERO;
			host_valid <= 1'b0;
		end else if (ce) begin
			if (reg_wr && reg_addr == `FSS_REG_HOSTB) begin
				host_byte <= reg_wdata[7:0];
				host_valid <= 1'b1;
			end else if (byte_take || start_scan) begin
				host_valid <= 1'b0;
			end
		end
	end

	// Deadline counter while the byte request is open
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			req_timer <= 10'h000;
		end else if (ce) begin
			if (scan_data_req) begin
				req_timer <= req_timer + 10'h001;
			end else begin
				req_timer <= 10'h000;
			end
		end
	end

	// Scan sequencer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			scan_state <= fss_pkg::FSS_SC_IDLE;
			scan_op <= 3'h0;
			scan_drv <= 2'h0;
			scan_head <= 1'b0;
			cur_sector <= `FSS_BYTE_ZERO;
			sec_all_cond <= 1'b1;
			sec_all_eq <= 1'b1;
			tc_seen <= 1'b0;
			idx_seen <= 1'b0;
			last_forced <= 1'b0;
			cm_seen <= 1'b0;
			scan_res <= `FSS_WORD_ZERO;
			scan_int <= 1'b0;
		end else if (ce) begin
			if (reg_rd && reg_addr == `FSS_REG_SCANRES) begin
				scan_int <= 1'b0;
			end
			if (terminal_count && scan_busy) begin
				tc_seen <= 1'b1;
			end
			case (scan_state)
				fss_pkg::FSS_SC_IDLE: begin
					if (start_scan) begin
						scan_state <= fss_pkg::FSS_SC_HUNT;
						scan_op <= cmd_op;
						scan_drv <= cmd_drv;
						scan_head <= reg_wdata[`FSS_CMD_HEAD];
						cur_sector <= scanp[`FSS_SCANP_START];
						tc_seen <= 1'b0;
						idx_seen <= 1'b0;
						cm_seen <= 1'b0;
						last_forced <= 1'b0;
					end
				end
				fss_pkg::FSS_SC_HUNT: begin
					if (tc_seen || terminal_count) begin
						// No byte in flight, so stop at once with nothing matched
						scan_res <= {`FSS_IC_NORMAL, 1'b0, 1'b0, 1'b0, scan_head, scan_drv, 8'h00,
							1'b0, cm_seen, 6'h00, cur_sector};
						scan_int <= 1'b1;
						scan_state <= fss_pkg::FSS_SC_IDLE;
					end else if (disk_in.index && idx_seen) begin
						// Second index without the wanted sector: last sector never read
						scan_res <= {`FSS_IC_ABNORMAL, 1'b0, 1'b0, 1'b0, scan_head, scan_drv,
							8'h80, 1'b0, cm_seen, 6'h00, cur_sector};
						scan_int <= 1'b1;
						scan_state <= fss_pkg::FSS_SC_IDLE;
					end else if (disk_in.sector_begin && disk_in.sector_id == cur_sector) begin
						sec_all_cond <= 1'b1;
						sec_all_eq <= 1'b1;
						if (disk_in.deleted) begin
							cm_seen <= 1'b1;
							if (scanp[`FSS_SCANP_SKIP]) begin
								scan_state <= fss_pkg::FSS_SC_SKIP;
							end else begin
								last_forced <= 1'b1;
								scan_state <= fss_pkg::FSS_SC_DATA;
							end
						end else begin
							scan_state <= fss_pkg::FSS_SC_DATA;
						end
					end else if (disk_in.index) begin
						idx_seen <= 1'b1;
					end
				end
				fss_pkg::FSS_SC_SKIP: begin
					if (disk_in.sector_end) begin
						if (cur_sector == scanp[`FSS_SCANP_LAST]) begin
							scan_res <= {`FSS_IC_NORMAL, 1'b0, 1'b0, 1'b0, scan_head, scan_drv, 8'h00,
								1'b0, 1'b1, 6'h01 << `FSS_ST2_SN, cur_sector};
							scan_int <= 1'b1;
							scan_state <= fss_pkg::FSS_SC_IDLE;
						end else begin
							cur_sector <= cur_sector + scanp[`FSS_SCANP_STEP];
							idx_seen <= 1'b0;
							scan_state <= fss_pkg::FSS_SC_HUNT;
						end
					end
				end
				fss_pkg::FSS_SC_DATA: begin
					if (req_late) begin
						scan_res <= {`FSS_IC_ABNORMAL, 1'b0, 1'b0, 1'b0, scan_head, scan_drv,
							8'h01 << `FSS_ST1_OR, 1'b0, cm_seen, 6'h00, cur_sector};
						scan_int <= 1'b1;
						scan_state <= fss_pkg::FSS_SC_IDLE;
					end else if (tc_seen) begin
						// Byte taken last cycle is already folded in; report what stands
						scan_res <= {`FSS_IC_NORMAL, 1'b0, 1'b0, 1'b0, scan_head, scan_drv, 8'h00,
							1'b0, cm_seen, 2'b00, sec_all_eq && sec_all_cond, 3'b000, cur_sector};
						scan_int <= 1'b1;
						scan_state <= fss_pkg::FSS_SC_IDLE;
					end else if (byte_take) begin
						if (!fss_cond(scan_op, disk_in.data, host_byte)) begin
							sec_all_cond <= 1'b0;
						end
						if (disk_in.data != host_byte) begin
							sec_all_eq <= 1'b0;
						end
					end else if (disk_in.sector_end) begin
						if (sec_all_cond) begin
							// Equal gives hit; strict inequality gives neither flag
							scan_res <= {`FSS_IC_NORMAL, 1'b0, 1'b0, 1'b0, scan_head, scan_drv, 8'h00,
								1'b0, cm_seen, 2'b00, sec_all_eq, 3'b000, cur_sector};
							scan_int <= 1'b1;
							scan_state <= fss_pkg::FSS_SC_IDLE;
						end else if (last_forced || cur_sector == scanp[`FSS_SCANP_LAST]) begin
							scan_res <= {`FSS_IC_NORMAL, 1'b0, 1'b0, 1'b0, scan_head, scan_drv, 8'h00,
								1'b0, cm_seen, 6'h01 << `FSS_ST2_SN, cur_sector};
							scan_int <= 1'b1;
							scan_state <= fss_pkg::FSS_SC_IDLE;
						end else begin
							cur_sector <= cur_sector + scanp[`FSS_SCANP_STEP];
							idx_seen <= 1'b0;
							scan_state <= fss_pkg::FSS_SC_HUNT;
						end
					end else if (disk_in.index) begin
						scan_res <= {`FSS_IC_ABNORMAL, 1'b0, 1'b0, 1'b0, scan_head, scan_drv,
							8'h80, 1'b0, cm_seen, 6'h00, cur_sector};
						scan_int <= 1'b1;
						scan_state <= fss_pkg::FSS_SC_IDLE;
					end
				end
				default: scan_state <= fss_pkg::FSS_SC_IDLE;
			endcase
			if (scan_busy && (terminal_count || tc_seen) && scan_state == fss_pkg::FSS_SC_SKIP) begin
				scan_state <= fss_pkg::FSS_SC_IDLE;
				scan_int <= 1'b1;
				scan_res <= {`FSS_IC_NORMAL, 1'b0, 1'b0, 1'b0, scan_head, scan_drv, 8'h00,
					1'b0, 1'b1, 6'h00, cur_sector};
			end
		end
	end

	// Per-drive seek and recalibrate engines, pending events and sense
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < DRIVES; i++) begin
				drv_state[i] <= fss_pkg::FSS_DRV_IDLE;
				present_cylinder[i] <= `FSS_BYTE_ZERO;
				target_cylinder[i] <= `FSS_BYTE_ZERO;
				step_timer[i] <= 24'h000000;
				step_count[i] <= 7'h00;
				pend_st0[i] <= `FSS_BYTE_ZERO;
			end
			drv_head <= '0;
			pend <= '0;
			pend_seek <= '0;
			rdy_q <= '0;
			drive_step <= '0;
			drive_dir <= '0;
			sense_res_st0 <= `FSS_BYTE_ZERO;
			sense_res_pcn <= `FSS_BYTE_ZERO;
		end else if (ce) begin
			rdy_q <= drive_ready;
			drive_step <= '0;
			// Sense takes the lowest pending drive; an event below still sets it again
			if (sense_cmd && sel_found) begin
				sense_res_st0 <= pend_st0[sel_idx];
				sense_res_pcn <= present_cylinder[sel_idx];
				pend[sel_idx] <= 1'b0;
				pend_seek[sel_idx] <= 1'b0;
			end else if (cmd_invalid || (sense_cmd && !sel_found)) begin
				sense_res_st0 <= {`FSS_IC_INVALID, 6'h00};
				sense_res_pcn <= `FSS_BYTE_ZERO;
			end
			for (int i = 0; i < DRIVES; i++) begin
				case (drv_state[i])
					fss_pkg::FSS_DRV_IDLE: begin
						if (rdy_q[i] != drive_ready[i]) begin
							pend[i] <= 1'b1;
							pend_st0[i] <= {`FSS_IC_READY, 3'b000, drv_head[i], 2'(i)};
						end
					end
					fss_pkg::FSS_DRV_SEEK: begin
						if (!drive_ready[i]) begin
							drv_state[i] <= fss_pkg::FSS_DRV_IDLE;
							pend[i] <= 1'b1;
							pend_seek[i] <= 1'b1;
							pend_st0[i] <= {`FSS_IC_ABNORMAL, 3'b101, drv_head[i], 2'(i)};
						end else if (present_cylinder[i] == target_cylinder[i]) begin
							drv_state[i] <= fss_pkg::FSS_DRV_IDLE;
							pend[i] <= 1'b1;
							pend_seek[i] <= 1'b1;
							pend_st0[i] <= {`FSS_IC_NORMAL, 3'b100, drv_head[i], 2'(i)};
						end else if (step_timer[i] >= step_limit) begin
							step_timer[i] <= 24'h000000;
							drive_step[i] <= 1'b1;
							if (present_cylinder[i] < target_cylinder[i]) begin
								drive_dir[i] <= 1'b1;
								present_cylinder[i] <= present_cylinder[i] + 8'h01;
							end else begin
								drive_dir[i] <= 1'b0;
								present_cylinder[i] <= present_cylinder[i] - 8'h01;
							end
						end else begin
							// Direction settles while waiting, so it moves with a step pulse only when a recalibrate starts in that cycle
							drive_dir[i] <= present_cylinder[i] < target_cylinder[i];
							step_timer[i] <= step_timer[i] + 24'h000001;
						end
					end
					fss_pkg::FSS_DRV_RECAL: begin
						if (!drive_ready[i]) begin
							drv_state[i] <= fss_pkg::FSS_DRV_IDLE;
							pend[i] <= 1'b1;
							pend_seek[i] <= 1'b1;
							pend_st0[i] <= {`FSS_IC_ABNORMAL, 3'b101, drv_head[i], 2'(i)};
						end else if (drive_track0[i]) begin
							drv_state[i] <= fss_pkg::FSS_DRV_IDLE;
							pend[i] <= 1'b1;
							pend_seek[i] <= 1'b1;
							pend_st0[i] <= {`FSS_IC_NORMAL, 3'b100, drv_head[i], 2'(i)};
						end else if (step_count[i] == `FSS_RECAL_MAX_STEPS) begin
							drv_state[i] <= fss_pkg::FSS_DRV_IDLE;
							pend[i] <= 1'b1;
							pend_seek[i] <= 1'b1;
							pend_st0[i] <= {`FSS_IC_ABNORMAL, 3'b110, drv_head[i], 2'(i)};
						end else if (step_timer[i] >= step_limit) begin
							step_timer[i] <= 24'h000000;
							drive_step[i] <= 1'b1;
							step_count[i] <= step_count[i] + 7'h01;
						end else begin
							step_timer[i] <= step_timer[i] + 24'h000001;
						end
					end
					default: drv_state[i] <= fss_pkg::FSS_DRV_IDLE;
				endcase
				// Starting a seek or recalibrate on this drive overrides its engine
				if (cmd_wr && !cmd_invalid && cmd_drv == 2'(i)
					&& (cmd_op == `FSS_OP_SEEK || cmd_op == `FSS_OP_RECAL)) begin
					drv_head[i] <= reg_wdata[`FSS_CMD_HEAD];
					step_timer[i] <= 24'h000000;
					step_count[i] <= 7'h00;
					if (cmd_op == `FSS_OP_SEEK) begin
						target_cylinder[i] <= target_reg;
						drv_state[i] <= fss_pkg::FSS_DRV_SEEK;
					end else begin
						present_cylinder[i] <= `FSS_BYTE_ZERO;
						target_cylinder[i] <= `FSS_BYTE_ZERO;
						drive_dir[i] <= 1'b1;
						drv_state[i] <= fss_pkg::FSS_DRV_RECAL;
					end
				end
			end
		end
	end

	// Register read port, data one cycle after the strobe
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= `FSS_WORD_ZERO;
		end else if (ce) begin
			reg_rdata <= `FSS_WORD_ZERO;
			if (reg_rd) begin
				case (reg_addr)
					`FSS_REG_SPEC: reg_rdata <= spec;
					`FSS_REG_SCANP: reg_rdata <= scanp;
					`FSS_REG_TARGET: reg_rdata <= {24'h000000, target_reg};
					`FSS_REG_HOSTB: reg_rdata <= {23'h000000, host_valid, host_byte};
					`FSS_REG_STATUS: reg_rdata <= {20'h00000, 4'(pend_seek), 4'(pend),
						need_sense, scan_data_req, scan_int, scan_busy};
					`FSS_REG_SCANRES: reg_rdata <= scan_res;
					`FSS_REG_SENSE: reg_rdata <= {16'h0000, sense_res_pcn, sense_res_st0};
					default: reg_rdata <= `FSS_WORD_ZERO;
				endcase
			end
		end
	end

endmodule

//--- rtl/fss_map.svh
// Purpose: Register map, field positions and timing figures of the scan/seek/sense block
// Assumes: 32-bit register port with byte addresses, 25 MHz clock
// Notes: Included by the block and its package users; definitions only
`ifndef FSS_MAP_SVH
`define FSS_MAP_SVH

// Register byte addresses
`define FSS_REG_CMD 8'h00
`define FSS_REG_SPEC 8'h04
`define FSS_REG_SCANP 8'h08
`define FSS_REG_TARGET 8'h0C
`define FSS_REG_HOSTB 8'h10
`define FSS_REG_STATUS 8'h14
`define FSS_REG_SCANRES 8'h18
`define FSS_REG_SENSE 8'h1C

// Command register fields
`define FSS_CMD_OP 2:0
`define FSS_CMD_DRV 5:4
`define FSS_CMD_HEAD 6
`define FSS_OP_SCAN_EQ 3'h1
`define FSS_OP_SCAN_LE 3'h2
`define FSS_OP_SCAN_GE 3'h3
`define FSS_OP_SEEK 3'h4
`define FSS_OP_RECAL 3'h5
`define FSS_OP_SENSE 3'h6

// Specify register fields
`define FSS_SPEC_SRT 3:0
`define FSS_SPEC_DD 8

// Scan parameter register fields
`define FSS_SCANP_START 7:0
`define FSS_SCANP_LAST 15:8
`define FSS_SCANP_STEP 23:16
`define FSS_SCANP_SKIP 24

// Target register field
`define FSS_TARGET_CYL 7:0

// Status register bit positions
`define FSS_ST0_SE 5
`define FSS_ST0_EC 4
`define FSS_ST0_NR 3
`define FSS_ST0_HD 2
`define FSS_ST0_IC 7:6
`define FSS_ST1_EN 7
`define FSS_ST1_OR 4
`define FSS_ST2_CM 6
`define FSS_ST2_SH 3
`define FSS_ST2_SN 2

// Interrupt codes
`define FSS_IC_NORMAL 2'h0
`define FSS_IC_ABNORMAL 2'h1
`define FSS_IC_INVALID 2'h2
`define FSS_IC_READY 2'h3

// Reset values
`define FSS_SPEC_RST 32'h0000_0000
`define FSS_SCANP_RST 32'h0000_0101
`define FSS_BYTE_ZERO 8'h00
`define FSS_WORD_ZERO 32'h0000_0000

// Timing figures
`define FSS_CLK_NS 40
`define FSS_FM_LIMIT_NS 27000
`define FSS_MFM_LIMIT_NS 13000
`define FSS_MS_NS 1000000
`define FSS_SRT_SPAN 5'h10
`define FSS_RECAL_MAX_STEPS 7'h4D

`endif

//--- rtl/fss_pkg.sv
// Purpose: Types shared by the scan/seek/sense block
// Assumes: Nothing beyond the map header
// Notes: Disk-side stream travels as one packed struct
package fss_pkg;

	// One cycle of the disk data separator
	typedef struct packed {
		logic sector_begin;
		logic deleted;
		logic [7:0] sector_id;
		logic byte_valid;
		logic [7:0] data;
		logic sector_end;
		logic index;
	} fss_disk_t;

	typedef enum logic [1:0] {
		FSS_SC_IDLE,
		FSS_SC_HUNT,
		FSS_SC_DATA,
		FSS_SC_SKIP
	} fss_scan_state_t;

	typedef enum logic [1:0] {
		FSS_DRV_IDLE,
		FSS_DRV_SEEK,
		FSS_DRV_RECAL
	} fss_drv_state_t;

endpackage

//--- verification/fss_core_checker.sv
// Purpose: Port assertions for the scan/seek/sense block
// Assumes: Shortest step interval is five cycles
// Notes: Drive 0 stands for every drive in the spacing and direction checks; the ready check covers all drives
`timescale 1ns/10ps
`include "fss_map.svh"
module fss_core_checker #(
	parameter int DRIVES = 4,
	parameter int STEP_UNIT_CYCLES = 25000
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire fss_pkg::fss_disk_t disk_in,
	input wire logic terminal_count,
	input wire logic scan_data_req,
	input wire logic [DRIVES-1:0] drive_ready,
	input wire logic [DRIVES-1:0] drive_track0,
	input wire logic [DRIVES-1:0] drive_step,
	input wire logic [DRIVES-1:0] drive_dir,
	input wire logic ctrl_busy,
	input wire logic ctrl_int
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// Command writes seen on the register port
	wire logic cmd_wr = ce && reg_wr && reg_addr == `FSS_REG_CMD;
	wire logic [2:0] op = reg_wdata[`FSS_CMD_OP];
	chk_rdata_idle: assert property ($past(ce) && !$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its slot");
	chk_step_spacing: assert property (drive_step[0] |=> !drive_step[0] [*4])
		else $error("step pulses too close");
	chk_dir_steady: assert property (drive_step[0] |-> $stable(drive_dir[0]))
		else $error("direction moved at a step");
	chk_step_ready: assert property ((drive_step & ~$past(drive_ready)) == '0)
		else $error("step to a drive not ready");
	chk_req_scan: assert property (scan_data_req |-> ctrl_busy)
		else $error("byte request outside a scan");
	chk_scan_int: assert property ($fell(ctrl_busy) |-> ctrl_int)
		else $error("scan end without interrupt");
	chk_scan_start: assert property (cmd_wr && op inside {3'h1, 3'h2, 3'h3} && !ctrl_busy && !ctrl_int
		|=> ctrl_busy)
		else $error("scan not started");
	chk_seek_idle: assert property (cmd_wr && op inside {3'h4, 3'h5} && !ctrl_busy |=> !ctrl_busy [*2])
		else $error("busy during seek");
	cover property (drive_step[0] && drive_dir[0]);
	cover property ($fell(ctrl_busy));
	cover property (scan_data_req);
endmodule
bind fss_core fss_core_checker #(.DRIVES(DRIVES), .STEP_UNIT_CYCLES(STEP_UNIT_CYCLES)) u_fss_core_checker (
	.clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .disk_in(disk_in), .terminal_count(terminal_count),
	.scan_data_req(scan_data_req), .drive_ready(drive_ready), .drive_track0(drive_track0),
	.drive_step(drive_step), .drive_dir(drive_dir), .ctrl_busy(ctrl_busy), .ctrl_int(ctrl_int));

//--- verification/fss_core_test.sv
// Purpose: Self-checking bench for the scan/seek/sense block
// Assumes: Step unit of four cycles, drives from fss_drive_model
// Notes: Disk stream and host bytes come from the tasks below
`timescale 1ns/10ps
`include "fss_map.svh"
module fss_core_test;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic terminal_count = 1'b0;
	logic ce = 1'b1;
	logic [3:0] present = 4'hF;
	fss_pkg::fss_disk_t disk = '0;
	logic [31:0] reg_rdata, q;
	logic scan_data_req, ctrl_busy, ctrl_int, late = 1'b0, tc = 1'b0;
	logic [3:0] drive_ready, drive_track0, drive_step, drive_dir;
	logic [7:0] hb = 8'h00;
	logic [31:0] rows [8] = '{32'h0105_0508, 32'h0105_0604, 32'h0205_0600, 32'h0206_0504,
		32'h0306_0500, 32'h0305_0604, 32'h03FF_0000, 32'h0200_FF00};
	int fail_count = 0;
	int n_checks = 0;
	int steps2 = 0;
	int s0;
	// Clock and step counter of drive 2
	initial begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) if (drive_step[2]) steps2++;
	fss_core #(.DRIVES(4), .STEP_UNIT_CYCLES(4)) u_fss_core (.clk(clk), .sys_rst(sys_rst), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.disk_in(disk), .terminal_count(terminal_count), .scan_data_req(scan_data_req),
		.drive_ready(drive_ready), .drive_track0(drive_track0), .drive_step(drive_step),
		.drive_dir(drive_dir), .ctrl_busy(ctrl_busy), .ctrl_int(ctrl_int));
	fss_drive_model u_fss_drive_model (.clk(clk), .sys_rst(sys_rst), .present(present),
		.drive_step(drive_step), .drive_dir(drive_dir), .drive_ready(drive_ready), .drive_track0(drive_track0));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
		@(posedge clk);
	endtask
	// Bounded wait for interrupt or for busy to drop
	task automatic wait_for(input bit want_int);
		int i;
		for (i = 0; i < 3000; i++) begin
			if (want_int ? ctrl_int === 1'b1 : ctrl_busy === 1'b0) break;
			@(posedge clk);
		end
		if (i == 3000) begin
			fail_count++;
			final_report();
		end
	endtask
	task automatic sense(input logic [15:0] e);
		wr(`FSS_REG_CMD, 32'h6);
		rd(`FSS_REG_SENSE);
		chk(q, {16'h0, e});
	endtask
	task automatic seek(input logic [31:0] c, input logic [15:0] e);
		wr(`FSS_REG_CMD, c);
		wait_for(1'b1);
		sense(e);
	endtask
	task automatic pulse(input fss_pkg::fss_disk_t v, input logic t);
		disk <= v;
		terminal_count <= t;
		@(posedge clk);
		disk <= '0;
		terminal_count <= 1'b0;
		@(posedge clk);
	endtask
	// One-byte sector; host byte written when requested unless late
	task automatic sec(input logic [7:0] id, input logic del, input logic [7:0] d);
		pulse('{sector_begin: 1'b1, deleted: del, sector_id: id, default: '0}, 1'b0);
		if (scan_data_req === 1'b1 && !late) wr(`FSS_REG_HOSTB, {24'h0, hb});
		pulse('{byte_valid: 1'b1, data: d, default: '0}, tc);
		pulse('{sector_end: 1'b1, default: '0}, 1'b0);
	endtask
	task automatic scan(input logic [31:0] p, input logic [2:0] op);
		wr(`FSS_REG_SCANP, p);
		wr(`FSS_REG_CMD, {29'h0, op});
	endtask
	task automatic scan_end(input logic [23:0] e, input logic [23:0] m);
		wait_for(1'b0);
		chk({31'h0, ctrl_int}, 32'h1);
		rd(`FSS_REG_SCANRES);
		chk({8'h0, q[31:8] & m}, {8'h0, e});
		chk({31'h0, ctrl_int}, 32'h0);
	endtask
	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		wait_for(1'b1);
		for (int i = 0; i < 4; i++) sense(16'h00C0 + 16'(i));
		sense(16'h0080);
		wr(`FSS_REG_SPEC, 32'hF);
		wr(`FSS_REG_TARGET, 32'h3);
		seek(32'h44, 16'h0324);
		wr(`FSS_REG_TARGET, 32'h2);
		wr(`FSS_REG_CMD, 32'h14);
		wr(`FSS_REG_TARGET, 32'h9);
		wr(`FSS_REG_CMD, 32'h04);
		wait_for(1'b1);
		wr(`FSS_REG_CMD, 32'h1);
		rd(`FSS_REG_SENSE);
		chk(q, 32'h0080);
		sense(16'h0221);
		wait_for(1'b1);
		sense(16'h0920);
		chk({31'h0, drive_dir[0]}, 32'h1);
		wr(`FSS_REG_TARGET, 32'h1);
		seek(32'h04, 16'h0120);
		chk({31'h0, drive_dir[0]}, 32'h0);
		seek(32'h25, 16'h0022);
		wr(`FSS_REG_TARGET, 32'h2);
		seek(32'h24, 16'h0222);
		s0 = steps2;
		seek(32'h25, 16'h0072);
		chk({24'h0, q[7:0]}, 32'h72);
		chk(steps2 - s0, 32'h4D);
		present <= 4'h7;
		wait_for(1'b1);
		sense(16'h00C3);
		seek(32'h34, 16'h006B);
		present <= 4'hF;
		wait_for(1'b1);
		sense(16'h00C3);
		// A write while the clock enable is low must leave the target untouched
		ce <= 1'b0;
		wr(`FSS_REG_TARGET, 32'h55);
		ce <= 1'b1;
		rd(`FSS_REG_TARGET);
		chk(q, 32'h2);
		for (int i = 0; i < 8; i++) begin
			hb = rows[i][15:8];
			scan(32'h0001_0101, rows[i][26:24]);
			sec(8'h01, 1'b0, rows[i][23:16]);
			scan_end({16'h0, rows[i][7:0]}, '1);
		end
		hb = 8'h07;
		scan(32'h0002_0301, 3'h1);
		sec(8'h01, 1'b0, 8'h06);
		sec(8'h02, 1'b0, 8'h07);
		sec(8'h03, 1'b0, 8'h07);
		scan_end(24'h000008, '1);
		scan(32'h0101_0201, 3'h1);
		sec(8'h01, 1'b1, 8'h07);
		sec(8'h02, 1'b0, 8'h07);
		scan_end(24'h000048, '1);
		scan(32'h0001_0201, 3'h1);
		sec(8'h01, 1'b1, 8'h06);
		scan_end(24'h000044, '1);
		scan(32'h0002_0201, 3'h1);
		sec(8'h01, 1'b0, 8'h06);
		pulse('{index: 1'b1, default: '0}, 1'b0);
		pulse('{index: 1'b1, default: '0}, 1'b0);
		scan_end(24'h408000, 24'hFFFF00);
		late = 1'b1;
		scan(32'h0001_0101, 3'h1);
		sec(8'h01, 1'b0, 8'h07);
		late = 1'b0;
		scan_end(24'h401000, 24'hFFFF00);
		tc = 1'b1;
		scan(32'h0001_0301, 3'h1);
		sec(8'h01, 1'b0, 8'h05);
		tc = 1'b0;
		scan_end(24'h000000, '1);
		final_report();
	end
endmodule

//--- verification/fss_drive_model.sv
// Purpose: Behavioural disk drives on the far side of the seek logic
// Assumes: One head position per drive, track zero sensor at cylinder 0
// Notes: Direction high moves the head up one cylinder per step
`timescale 1ns/10ps
module fss_drive_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [3:0] present,
	input wire logic [3:0] drive_step,
	input wire logic [3:0] drive_dir,
	output logic [3:0] drive_ready,
	output logic [3:0] drive_track0
);
	logic [7:0] cyl [4];
	// Head position follows each step pulse
	always_ff @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (sys_rst) begin
				cyl[i] <= 8'h00;
			end else if (drive_step[i]) begin
				cyl[i] <= drive_dir[i] ? cyl[i] + 8'h01 : cyl[i] - 8'h01;
			end
		end
	end
	// Ready follows disk presence; track zero sensor
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			drive_ready[i] = present[i];
			drive_track0[i] = cyl[i] == 8'h00;
		end
	end
endmodule
